// ===== rtl/afc_ctrl.sv
// host controller driving one asynchronous nine-bit fifo through its pins
`timescale 1ns/10ps
`include "afc_defs.svh"
module afc_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // device pins
  output logic clear_in_n,
  output logic push_n,
  output logic pop_n,
  output logic replay_in_n,
  output logic chain_in_n,
  output afc_pkg::afc_word_t din,
  input wire logic [8:0] dout,
  input wire logic drained_flag_n,
  input wire logic topped_flag_n,
  input wire logic midway_flag_n
);
  import afc_pkg::*;

  localparam int NP = `AFC_N_PULSE;
  localparam int NR = `AFC_N_RECOV;
  localparam int NS = `AFC_N_RSC;

  afc_state_t st_q;
  logic [1:0] cmd_q;
  logic [7:0] cnt_q;
  logic [11:0] sy;
  afc_word_t rx_q;
  logic err_q;
  logic [15:0] pushes_q;
  logic [15:0] pops_q;
  logic [15:0] refused_q;
  logic go;
  logic busy;

  afc_sync #(.W(12)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .pin_in({midway_flag_n, topped_flag_n, drained_flag_n, dout}),
    .pin_sync(sy)
  );

  // one device's flags stand for the whole array when widened
  wire drained_s = sy[9];
  wire topped_s = sy[10];
  wire midway_s = sy[11];

  assign busy = (st_q != AFC_IDLE);
  assign go = wr && (addr == `AFC_A_CTRL) && !busy;
  // standalone mode: chain input held low, so no chain head, ring or composite flags
  assign chain_in_n = 1'b0;

  // command sequencer: one strobe pulse, then recovery
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= AFC_IDLE;
      cmd_q <= 2'h0;
      cnt_q <= 8'h00;
    end else if (ce) begin
      case (st_q)
        AFC_IDLE: begin
          cnt_q <= 8'h00;
          if (go) begin
            cmd_q <= wdata[1:0];
            st_q <= AFC_LOW;
          end
        end
        AFC_LOW: begin
          if (cnt_q == 8'(NP - 1)) begin
            cnt_q <= 8'h00;
            st_q <= AFC_HIGH;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        AFC_HIGH: begin
          // clear needs reset cycle time before flags are trusted
          if (cnt_q == 8'((cmd_q == 2'(`AFC_CMD_CLEAR)) ? NS : NR)) begin
            cnt_q <= 8'h00;
            st_q <= AFC_SETTLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        AFC_SETTLE: begin
          // three extra cycles let synchronised flags catch up
          if (cnt_q == 8'h02) begin
            st_q <= AFC_DONE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        AFC_DONE: st_q <= AFC_IDLE;
        default: st_q <= AFC_IDLE;
      endcase
    end
  end

  // strobes: only the chosen one goes low, so push and pop stay high during clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clear_in_n <= 1'b1;
    end else if (ce) begin
      clear_in_n <= !(st_q == AFC_LOW && cmd_q == 2'(`AFC_CMD_CLEAR));
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      replay_in_n <= 1'b1;
    end else if (ce) begin
      replay_in_n <= !(st_q == AFC_LOW && cmd_q == 2'(`AFC_CMD_REPLAY));
    end
  end

  // push only when not topped; checked at launch, held through the pulse
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      push_n <= 1'b1;
    end else if (ce) begin
      push_n <= !(st_q == AFC_LOW && cmd_q == 2'(`AFC_CMD_PUSH) && !err_q);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pop_n <= 1'b1;
    end else if (ce) begin
      pop_n <= !(st_q == AFC_LOW && cmd_q == 2'(`AFC_CMD_POP) && !err_q);
    end
  end

  // refused attempt: push on topped or pop on drained is skipped and flagged
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      err_q <= 1'b0;
    end else if (ce) begin
      if (go) begin
        err_q <= (wdata[1:0] == 2'(`AFC_CMD_PUSH) && !topped_s) ||
                 (wdata[1:0] == 2'(`AFC_CMD_POP) && !drained_s);
      end
    end
  end

  // outgoing word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      din <= 9'h000;
    end else if (ce && wr && addr == `AFC_A_WDATA && !busy) begin
      din <= wdata[8:0];
    end
  end

  // capture read word late in the pop pulse, before it floats
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_q <= 9'h000;
    end else if (ce && st_q == AFC_LOW && cmd_q == 2'(`AFC_CMD_POP) && !err_q &&
                 cnt_q == 8'(NP - 1)) begin
      rx_q <= sy[8:0];
    end
  end

  // transfer counters, cleared by a clear command
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pushes_q <= 16'h0000;
      pops_q <= 16'h0000;
    end else if (ce && st_q == AFC_DONE) begin
      if (cmd_q == 2'(`AFC_CMD_CLEAR)) begin
        pushes_q <= 16'h0000;
        pops_q <= 16'h0000;
      end else if (cmd_q == 2'(`AFC_CMD_PUSH) && !err_q) begin
        pushes_q <= pushes_q + 16'h0001;
      end else if (cmd_q == 2'(`AFC_CMD_POP) && !err_q) begin
        pops_q <= pops_q + 16'h0001;
      end
    end
  end

  // refused attempts since the last clear, so software can spot a dropped word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      refused_q <= 16'h0000;
    end else if (ce && st_q == AFC_DONE) begin
      if (cmd_q == 2'(`AFC_CMD_CLEAR)) begin
        refused_q <= 16'h0000;
      end else if (err_q) begin
        refused_q <= refused_q + 16'h0001;
      end
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (rd) begin
        case (addr)
          `AFC_A_CTRL: rdata <= {30'h0, cmd_q};
          `AFC_A_STAT: rdata <= {27'h0, err_q, busy, midway_s, topped_s, drained_s};
          `AFC_A_WDATA: rdata <= {23'h0, din};
          `AFC_A_RDATA: rdata <= {23'h0, rx_q};
          `AFC_A_COUNT: rdata <= {pops_q, pushes_q};
          `AFC_A_REFUSED: rdata <= {16'h0000, refused_q};
          default: rdata <= 32'h0000_0000;
        endcase
      end else begin
        rdata <= 32'h0000_0000;
      end
    end
  end
endmodule // afc_ctrl

// ===== rtl/afc_defs.svh
// timing counts, widths and codes for the fifo pin controller
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH
// How it works
// - push and pop strobes are held high around the clear rising edge.
// - writer watches topped flag, reader watches drained flag.
// - chain head low on first device, high on all others.
// - each chain output feeds the next device chain input.
// - composite drained and topped flags assert only when all devices assert.
// - width expansion drives controls in parallel; one device's flags suffice.
// - push is toggled only while topped flag is not asserted.
`define AFC_DW 9
// strobe low, strobe high and reset cycle times at 8 ns per cycle
`define AFC_T_PULSE_NS 120
`define AFC_T_RECOV_NS 20
`define AFC_T_RSC_NS 140
`define AFC_CYC(ns) (((ns) + 7) / 8)
`define AFC_N_PULSE `AFC_CYC(`AFC_T_PULSE_NS)
`define AFC_N_RECOV `AFC_CYC(`AFC_T_RECOV_NS)
`define AFC_N_RSC `AFC_CYC(`AFC_T_RSC_NS)
// register map
`define AFC_A_CTRL 4'h0
`define AFC_A_STAT 4'h1
`define AFC_A_WDATA 4'h2
`define AFC_A_RDATA 4'h3
`define AFC_A_COUNT 4'h4
`define AFC_A_REFUSED 4'h5
`define AFC_CMD_CLEAR 0
`define AFC_CMD_REPLAY 1
`define AFC_CMD_PUSH 2
`define AFC_CMD_POP 3
`endif

// ===== rtl/afc_pkg.sv
// types of the fifo pin controller
package afc_pkg;
  typedef enum logic [4:0] {
    AFC_IDLE = 5'h01,
    AFC_LOW = 5'h02,
    AFC_HIGH = 5'h04,
    AFC_SETTLE = 5'h08,
    AFC_DONE = 5'h10
  } afc_state_t;
  typedef logic [8:0] afc_word_t;
endpackage

// ===== rtl/afc_sync.sv
// bank of two-flop synchronisers for the device's flag and data pins
`timescale 1ns/10ps
module afc_sync #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // pins and synchronised copies
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // flags idle high, so reset to inactive
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          meta_q[i] <= 1'b1;
          pin_sync[i] <= 1'b1;
        end else if (ce) begin
          meta_q[i] <= pin_in[i];
          pin_sync[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // afc_sync

// ===== testbench/afc_ctrl_assertions.sv
// pin-protocol checker for the fifo host controller
`timescale 1ns/10ps
`include "afc_defs.svh"
module afc_ctrl_assertions (
  input wire logic clock, rstn, ce, wr, rd,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata, rdata,
  input wire logic clear_in_n, push_n, pop_n, replay_in_n, chain_in_n,
  input wire afc_pkg::afc_word_t din,
  input wire logic [8:0] dout,
  input wire logic drained_flag_n, topped_flag_n, midway_flag_n
);
  import afc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // pulse width is counted here, since a repetition cannot reach the full minimum
  logic [7:0] push_low_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      push_low_q <= 8'h00;
    end else if (ce) begin
      push_low_q <= push_n ? 8'h00 : push_low_q + 8'h01;
    end
  end
  // eight cycles covers the two-flop flag sync plus command latency
  sequence s_full; (!topped_flag_n)[*8]; endsequence
  sequence s_empty; (!drained_flag_n)[*8]; endsequence
  sequence s_clear_end; $rose(clear_in_n); endsequence
  chk_clear_quiet: assert property (!clear_in_n |-> push_n && pop_n && replay_in_n)
    else $error("strobe low during clear");
  chk_clear_recover: assert property (s_clear_end |-> (push_n && pop_n)[*3])
    else $error("strobe low too soon after clear");
  chk_push_full: assert property (s_full |-> !$fell(push_n))
    else $error("push started on full device");
  chk_pop_empty: assert property (s_empty |-> !$fell(pop_n))
    else $error("pop started on empty device");
  chk_chain_single: assert property (chain_in_n == 1'b0)
    else $error("chain input not grounded");
  chk_replay_quiet: assert property (!replay_in_n |-> push_n && pop_n)
    else $error("strobe low during replay");
  chk_push_width: assert property ($fell(push_n) |-> (!push_n)[*8])
    else $error("push pulse too short");
  chk_push_long: assert property ($rose(push_n) |-> push_low_q >= 8'(`AFC_N_PULSE))
    else $error("push pulse below minimum width");
endmodule // afc_ctrl_assertions
bind afc_ctrl afc_ctrl_assertions chk_i (.clock, .rstn, .ce, .wr, .rd, .addr, .wdata, .rdata, .clear_in_n,
  .push_n, .pop_n, .replay_in_n, .chain_in_n, .din, .dout, .drained_flag_n, .topped_flag_n, .midway_flag_n);

// ===== testbench/afc_ctrl_tb.sv
// self-checking bench for the fifo host controller
`timescale 1ns/10ps
module afc_ctrl_tb;
  import afc_pkg::*;
  localparam int DEPTH = 8;
  logic clock = 0, rstn = 0, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v, u;
  logic clear_in_n, push_n, pop_n, replay_in_n, chain_in_n, drained_flag_n, topped_flag_n, midway_flag_n;
  afc_word_t din;
  logic [8:0] dout;
  logic [8:0] q[$], all[$];
  int seed = 49, miscompares = 0, check_count = 0, i;
  afc_ctrl uut (.clock, .rstn, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata, .clear_in_n, .push_n, .pop_n,
    .replay_in_n, .chain_in_n, .din, .dout, .drained_flag_n, .topped_flag_n, .midway_flag_n);
  afc_fifo_model #(.DEPTH(DEPTH)) dev (.clear_in_n, .push_n, .pop_n, .replay_in_n, .chain_in_n, .din, .dout,
    .drained_flag_n, .topped_flag_n, .midway_flag_n);
  initial forever #4 clock = ~clock;
  task chk(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock); addr <= a; wdata <= d; wr <= 1;
    @(posedge clock); wr <= 0;
  endtask
  task rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock); addr <= a; rd <= 1;
    @(posedge clock); rd <= 0;
    @(negedge clock); d = rdata;
  endtask
  task cmd(input logic [1:0] c);
    int n;
    wreg(4'h0, {30'h0, c});
    n = 0;
    do begin rreg(4'h1, v); n++; end while (v[3] !== 1'b0 && n < 100);
    if (v[3] !== 1'b0) begin miscompares++; stop_test; end
  endtask
  task push(input logic [8:0] d);
    wreg(4'h2, {23'h0, d});
    cmd(2'h2);
    if (q.size() < DEPTH) begin q.push_back(d); all.push_back(d); end
  endtask
  task pop;
    cmd(2'h3);
    rreg(4'h3, v);
    if (q.size() > 0) chk(v[8:0], q.pop_front());
  endtask
  function logic [2:0] flags(int c);
    return {c <= DEPTH / 2, c != DEPTH, c != 0};
  endfunction
  task st;
    rreg(4'h1, v);
    chk(v[2:0], flags(q.size()));
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1;
    cmd(2'h0); st();
    for (i = 0; i < DEPTH; i++) begin push(9'($random(seed))); st(); end
    rreg(4'h4, u); push(9'h1FF); rreg(4'h1, v);
    chk(v[4], 1'b1);
    rreg(4'h4, v); chk(v, u);
    rreg(4'h5, v); chk(v, 32'h1);
    for (i = 0; i < DEPTH; i++) begin pop(); st(); end
    rreg(4'h4, u); pop(); rreg(4'h4, v); chk(v, u);
    rreg(4'h5, v); chk(v, 32'h2);
    $display("fill and drain done");
    cmd(2'h0); q = {}; all = {};
    rreg(4'h5, v); chk(v, 32'h0);
    for (i = 0; i < 3; i++) push(9'($random(seed)));
    pop(); cmd(2'h1); q = all;
    for (i = 0; i < 3; i++) pop();
    st();
    $display("replay done");
    for (i = 0; i < 2 * DEPTH + 3; i++) begin push(9'($random(seed))); pop(); end
    st(); $display("wrap done");
    stop_test;
  end
endmodule // afc_ctrl_tb

// ===== testbench/afc_fifo_model.sv
// behavioural model of the asynchronous nine-bit fifo device
`timescale 1ns/10ps
module afc_fifo_model #(
  parameter int DEPTH = 8
) (
  input wire logic clear_in_n, push_n, pop_n, replay_in_n, chain_in_n,
  input wire logic [8:0] din,
  output logic [8:0] dout,
  output logic drained_flag_n, topped_flag_n, midway_flag_n
);
  logic [8:0] mem [DEPTH];
  logic [8:0] last = 9'h000;
  logic half_n = 1'b1;
  int wp = 0, rp = 0, cnt = 0;
  always @(negedge clear_in_n) begin wp = 0; rp = 0; cnt = 0; half_n = 1'b1; end
  // replay exists in standalone mode only; in a chain the shared pin marks the head
  always @(negedge replay_in_n) if (clear_in_n && !chain_in_n) begin
    rp = 0;
    cnt = wp;
    half_n = !(cnt > DEPTH / 2);
  end
  // midway drops on the falling edge of the write that passes half
  always @(negedge push_n) if (clear_in_n && cnt >= DEPTH / 2 && cnt < DEPTH) half_n = 1'b0;
  always @(posedge push_n) if (clear_in_n && cnt < DEPTH) begin
    mem[wp] = din;
    wp = (wp + 1) % DEPTH;
    cnt++;
  end
  always @(posedge pop_n) if (clear_in_n && cnt > 0) begin
    last = mem[rp];
    rp = (rp + 1) % DEPTH;
    cnt--;
    if (cnt <= DEPTH / 2) half_n = 1'b1;
  end
  // outputs float when not reading: show a changed value, not stale data
  assign dout = !pop_n ? mem[rp] : ~last;
  assign drained_flag_n = cnt != 0;
  assign topped_flag_n = cnt != DEPTH;
  // standalone: the shared pin shows midway; the last-location chain pulse is not modelled
  assign midway_flag_n = half_n || chain_in_n;
endmodule // afc_fifo_model
